// ===== fault_onoff_supervisor_defines.vh
// Register map, field positions, reset values and timing for the supervisor.
`ifndef FAULT_ONOFF_SUPERVISOR_DEFINES_VH
`define FAULT_ONOFF_SUPERVISOR_DEFINES_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define REG_SYSTEM_STATUS    8'h00
`define REG_PIN_INPUT_LEVELS 8'h02
`define REG_LIVE_FAULTS      8'h03
`define REG_FAULT_LOG        8'h04
`define REG_ALARM_LOG_FIRST  8'h05
`define REG_ALARM_LOG_LAST   8'h09
`define REG_CONTROL_PRIMARY  8'h0A
`define REG_RETRY_CONTROL    8'h0B
`define REG_COOLDOWN_CONFIG  8'h0E
`define REG_FAULT_ACTION     8'h0F
`define REG_MULTIPIN_A_CFG   8'h10
`define REG_MULTIPIN_A_OUT   8'h11
`define REG_MULTIPIN_B_CFG   8'h12
`define REG_FAULT_ALERT_MASK 8'h15
`define REG_METER_CONTROL    8'h84
`define REG_REBOOT_CONTROL   8'hA2
`define REG_NVM_DEFAULT      8'hAA

// ****************************************************************
// Field positions
// ****************************************************************
`define FB_OV            0
`define FB_UV            1
`define FB_OC            2
`define FB_BAD           3
`define FB_SHORT         4
`define FB_OUTSIDE       5
`define FB_PWR_FAILED    6
`define FB_PG_INPUT      7
`define CTL_ON_BIT       3
`define CTL_CLI_ENABLE   5
`define ACT_GATE_KILL    7
`define COOL_SEL_HI      3
`define COOL_SEL_LO      1
`define PIN4_MODE_HI     7
`define PIN4_MODE_LO     6
`define MODE_GP_OUTPUT   2'h1
`define MODE_FAULT_LOW   2'h2
`define MODE_FAULT_HIGH  2'h3
`define ALM_PRES_TOGGLED 7
`define ALM_NVM_WRITTEN  6
`define MTR_TICK_WRAP    7
`define MTR_METER_WRAP   6
`define RBT_COOLING      1
`define SYS_PRESENCE     0
`define SYS_SWITCH_ON    1

// ****************************************************************
// Reset values and masks
// ****************************************************************
`define RST_BYTE         8'h00
`define KILL_BASE_MASK   8'h0F

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_HZ           10000000
`define TICK_US          1000
`define DEBOUNCE_MS      128
`define COOLDOWN_MIN_MS  512
`define SHORT_LIMIT_UV   255

`endif

// ===== fault_onoff_supervisor.v
// Fault logging and switch on/off supervision for a hot swap controller.
`timescale 1ns/100ps
`include "fault_onoff_supervisor_defines.vh"
module fault_onoff_supervisor #(
  parameter TICK_CYCLES = (`CLK_HZ / 1000000) * `TICK_US,
  parameter ON_DEFAULT  = 1'b0
) (
  // Clock and resets.
  input  wire        clk,
  input  wire        rst,
  input  wire        supply_lockout,
  // Internal register port from the serial interface engine.
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  // Pins and comparators from outside the clock domain.
  input  wire        presence_n,
  input  wire [7:0]  pin_cmp,
  input  wire        output_low_cmp,
  input  wire        uv_low_reset,
  // Status and events from device logic on this clock.
  input  wire        sense_valid,
  input  wire [15:0] sense_uv,
  input  wire        pg_latched,
  input  wire        ov_live,
  input  wire        uv_live,
  input  wire        oc_live,
  input  wire        bad_live,
  input  wire        pg_input_live,
  input  wire        oc_event,
  input  wire        bad_event,
  input  wire        reboot_cmd,
  input  wire [39:0] alarm_event,
  input  wire        nvm_written,
  input  wire        tick_wrap,
  input  wire        meter_wrap,
  // Outputs.
  output wire        switch_enable,
  output wire        alert_n_out,
  output wire        alert_n_oe,
  output reg  [7:0]  pin_out,
  output reg  [7:0]  pin_oe
);

  // ****************************************************************
  // Cooldown length
  // ****************************************************************
  function [16:0] cool_len;
    input [2:0] sel;
    begin
      cool_len = 17'd`COOLDOWN_MIN_MS << sel;
    end
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg        lock_q;
  reg  [1:0] pres_s;
  reg  [7:0] pin_s1;
  reg  [7:0] pin_s2;
  reg  [1:0] vlow_s;
  reg  [1:0] uvr_s;
  reg  [7:0] ctrl_q;
  reg  [7:0] retry_q;
  reg  [7:0] cool_cfg_q;
  reg  [7:0] act_q;
  reg  [7:0] mpa_cfg_q;
  reg  [7:0] mpa_out_q;
  reg  [7:0] mpb_q;
  reg  [7:0] amask_q;
  reg  [7:0] nvm_q;
  reg  [7:0] meter_q;
  reg  [7:0] alarm_q [0:4];
  reg  [7:0] fault_q;
  reg  [7:0] fault_d;
  reg        short_q;
  reg        pres_prev_q;
  reg        on_prev_q;
  reg        switch_q;
  reg  [7:0] deb_q;
  reg [31:0] tick_q;
  reg [16:0] cool_q;
  reg  [7:0] rd_d;
  reg  [2:0] ai;
  wire       srst;
  wire       wr_fault;
  wire       presence;
  wire       outside_live;
  wire [7:0] live;
  wire [7:0] set_ev;
  wire [7:0] kill;
  wire [7:0] cleared;
  wire       hold_off;
  wire       tick;
  wire       cooling;
  wire       cool_start;
  wire       deb_done;
  wire       on_fall;
  wire       pres_fall;
  wire       pres_chg;
  wire       clear_all;
  wire       permit;
  wire [1:0] pin4_mode;

  // ****************************************************************
  // Lockout and input synchronisers
  // ****************************************************************

  // Lockout asserts the whole-block reset at once; release is clocked.
  always @(posedge clk or posedge supply_lockout)
  begin
    if (supply_lockout)
      lock_q <= 1'b1;
    else
      lock_q <= 1'b0;
  end

  assign srst = rst | lock_q;

  // Two flops on every pin or comparator level before any logic.
  always @(posedge clk)
  begin
    pres_s <= {pres_s[0], presence_n};
    pin_s1 <= pin_cmp;
    pin_s2 <= pin_s1;
    vlow_s <= {vlow_s[0], output_low_cmp};
    uvr_s  <= {uvr_s[0], uv_low_reset};
  end

  assign presence = ~pres_s[1];

  // ****************************************************************
  // Live conditions and hold-off
  // ****************************************************************
  assign pin4_mode = mpa_cfg_q[`PIN4_MODE_HI:`PIN4_MODE_LO];

  // Pin four only becomes a fault source in the two fault modes.
  assign outside_live = (pin4_mode == `MODE_FAULT_LOW)  ? ~pin_s2[3] :
                        (pin4_mode == `MODE_FAULT_HIGH) ?  pin_s2[3] :
                        1'b0;

  // Short check is only meaningful while the switch is held off.
  always @(posedge clk)
  begin
    if (srst)
      short_q <= 1'b0;
    else if (sense_valid)
      short_q <= ~switch_q && (sense_uv > 16'd`SHORT_LIMIT_UV);
  end

  assign live = {pg_input_live, vlow_s[1], outside_live, short_q,
                 bad_live, oc_live, uv_live, ov_live};
  // Collapse logs only after power good latched; status bit does not.
  assign set_ev = {pg_input_live, vlow_s[1] & pg_latched, outside_live,
                   short_q, bad_live, oc_live, uv_live, ov_live};

  // Outside fault only joins the kill set when gate kill is on.
  assign kill = `KILL_BASE_MASK |
                ({7'h00, act_q[`ACT_GATE_KILL]} << `FB_OUTSIDE);
  // Retrying faults look at live state, latch-off faults at the log.
  assign hold_off = |(kill & ((retry_q & live) |
                              (~retry_q & fault_q)));

  // ****************************************************************
  // Shared tick, debounce and cooldown
  // ****************************************************************

  // A single millisecond prescaler times every delay in the block.
  always @(posedge clk)
  begin
    if (srst || tick)
      tick_q <= 32'h00000000;
    else
      tick_q <= tick_q + 32'h00000001;
  end

  assign tick = (tick_q == TICK_CYCLES - 1);

  // Any high sample restarts the debounce; it must run low unbroken.
  always @(posedge clk)
  begin
    if (srst || !presence)
      deb_q <= 8'h00;
    else if (tick && !deb_done)
      deb_q <= deb_q + 8'h01;
  end

  assign deb_done = (deb_q == 8'd`DEBOUNCE_MS);

  // A latch-off bit in the kill set other than overvoltage, cleared by software or by clear_all, starts the retry delay.
  assign cleared = fault_q & ~fault_d & kill & ~retry_q &
                   ~(8'h01 << `FB_OV);
  // Without gate kill the switch stays on, so no retry delay is owed.
  assign cool_start = oc_event | bad_event |
                      (outside_live & act_q[`ACT_GATE_KILL]) |
                      (|cleared);

  // Restart wins over expiry; only reboot, reset or lockout cut it short.
  always @(posedge clk)
  begin
    if (srst || reboot_cmd)
      cool_q <= 17'h00000;
    else if (cool_start)
      cool_q <= cool_len(cool_cfg_q[`COOL_SEL_HI:`COOL_SEL_LO]);
    else if (tick && cooling)
      cool_q <= cool_q - 17'h00001;
  end

  assign cooling = (cool_q != 17'h00000);

  // ****************************************************************
  // Switch control
  // ****************************************************************
  assign on_fall   = on_prev_q & ~ctrl_q[`CTL_ON_BIT];
  assign pres_chg  = pres_prev_q ^ presence;
  assign pres_fall = ~pres_prev_q & presence;
  assign clear_all = on_fall | pres_fall | uvr_s[1];

  // On bit acts without debounce once presence has debounced.
  assign permit = ctrl_q[`CTL_ON_BIT] & presence & deb_done &
                  ~hold_off & ~cooling;

  always @(posedge clk)
  begin
    if (srst)
    begin
      switch_q    <= 1'b0;
      on_prev_q   <= 1'b0;
      pres_prev_q <= 1'b0;
    end
    else
    begin
      switch_q    <= permit;
      on_prev_q   <= ctrl_q[`CTL_ON_BIT];
      pres_prev_q <= presence;
    end
  end

  // Lockout drops the gate combinationally, ahead of the reset flop.
  assign switch_enable = switch_q & ~supply_lockout;

  // ****************************************************************
  // Fault log
  // ****************************************************************
  assign wr_fault = reg_wr && (reg_addr == `REG_FAULT_LOG);

  // Set always wins; bits with a live cause refuse to clear.
  always @*
  begin
    if (clear_all)
      fault_d = set_ev;
    else if (wr_fault)
      fault_d = (fault_q & reg_wdata) | reg_wdata | live | set_ev;
    else
      fault_d = fault_q | set_ev;
    if (wr_fault && !clear_all)
      fault_d = (reg_wdata | live) | set_ev;
  end

  always @(posedge clk)
  begin
    if (srst)
      fault_q <= `RST_BYTE;
    else
      fault_q <= fault_d;
  end

  // Alert pulls low while any enabled logged fault is present.
  assign alert_n_oe  = |(fault_q & amask_q);
  assign alert_n_out = 1'b0;

  // ****************************************************************
  // Configuration and alarm registers
  // ****************************************************************
  always @(posedge clk)
  begin
    if (srst)
    begin
      ctrl_q     <= {4'h0, (ON_DEFAULT != 0), 3'h0};
      retry_q    <= `RST_BYTE;
      cool_cfg_q <= `RST_BYTE;
      act_q      <= `RST_BYTE;
      mpa_cfg_q  <= `RST_BYTE;
      mpa_out_q  <= `RST_BYTE;
      mpb_q      <= `RST_BYTE;
      amask_q    <= `RST_BYTE;
      nvm_q      <= `RST_BYTE;
      meter_q    <= `RST_BYTE;
    end
    else
    begin
      if (reg_wr)
      begin
        case (reg_addr)
          `REG_CONTROL_PRIMARY:  ctrl_q     <= reg_wdata;
          `REG_RETRY_CONTROL:    retry_q    <= reg_wdata;
          `REG_COOLDOWN_CONFIG:  cool_cfg_q <= reg_wdata;
          `REG_FAULT_ACTION:     act_q      <= reg_wdata;
          `REG_MULTIPIN_A_CFG:   mpa_cfg_q  <= reg_wdata;
          `REG_MULTIPIN_A_OUT:   mpa_out_q  <= reg_wdata;
          `REG_MULTIPIN_B_CFG:   mpb_q      <= reg_wdata;
          `REG_FAULT_ALERT_MASK: amask_q    <= reg_wdata;
          `REG_NVM_DEFAULT:      nvm_q      <= reg_wdata;
          default:               nvm_q      <= nvm_q;
        endcase
      end
      // Wrap bits are sticky; zero written clears, events win.
      if (reg_wr && reg_addr == `REG_METER_CONTROL)
        meter_q <= reg_wdata & ~({1'b1, 1'b1, 6'h00} & ~meter_q) |
                   {tick_wrap, meter_wrap, 6'h00};
      else
        meter_q <= meter_q | {tick_wrap, meter_wrap, 6'h00};
    end
  end

  // Alarm logs: sticky bits cleared by zero writes or reset; the presence toggle bit also by on bit falling or UV reset.
  always @(posedge clk)
  begin
    for (ai = 3'd0; ai < 3'd5; ai = ai + 3'd1)
    begin
      if (srst)
        alarm_q[ai] <= `RST_BYTE;
      else if (reg_wr && reg_addr == `REG_ALARM_LOG_FIRST + {5'h00, ai})
        alarm_q[ai] <= (alarm_q[ai] & reg_wdata) |
                       alarm_event[8*ai +: 8];
      else
        alarm_q[ai] <= alarm_q[ai] | alarm_event[8*ai +: 8];
      // The first log also carries presence toggle and memory write.
      if (!srst && ai == 3'd0)
      begin
        if (pres_chg)
          alarm_q[0][`ALM_PRES_TOGGLED] <= 1'b1;
        else if (on_fall || uvr_s[1])
          alarm_q[0][`ALM_PRES_TOGGLED] <= 1'b0;
        if (nvm_written)
          alarm_q[0][`ALM_NVM_WRITTEN] <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Multi-function pins
  // ****************************************************************
  always @(posedge clk)
  begin
    if (srst)
    begin
      pin_out <= 8'h00;
      pin_oe  <= 8'h00;
    end
    else
    begin
      pin_out <= {mpb_q[3:0], mpa_out_q[7:4]};
      pin_oe  <= {mpb_q[7:4],
                  mpa_cfg_q[7:6] == `MODE_GP_OUTPUT,
                  mpa_cfg_q[5:4] == `MODE_GP_OUTPUT,
                  mpa_cfg_q[3:2] == `MODE_GP_OUTPUT,
                  mpa_cfg_q[1:0] == `MODE_GP_OUTPUT};
      // Indicator pulls low at startup and in current limit.
      if (ctrl_q[`CTL_CLI_ENABLE])
      begin
        pin_out[1] <= 1'b0;
        pin_oe[1]  <= ~pg_latched | oc_live;
      end
    end
  end

  // ****************************************************************
  // Register read
  // ****************************************************************
  always @*
  begin
    rd_d = 8'h00;
    case (reg_addr)
      `REG_SYSTEM_STATUS:    rd_d = {6'h00, switch_q, pres_s[1]};
      `REG_PIN_INPUT_LEVELS: rd_d = pin_s2;
      `REG_LIVE_FAULTS:      rd_d = live;
      `REG_FAULT_LOG:        rd_d = fault_q;
      `REG_CONTROL_PRIMARY:  rd_d = ctrl_q;
      `REG_RETRY_CONTROL:    rd_d = retry_q;
      `REG_COOLDOWN_CONFIG:  rd_d = cool_cfg_q;
      `REG_FAULT_ACTION:     rd_d = act_q;
      `REG_MULTIPIN_A_CFG:   rd_d = mpa_cfg_q;
      `REG_MULTIPIN_A_OUT:   rd_d = mpa_out_q;
      `REG_MULTIPIN_B_CFG:   rd_d = mpb_q;
      `REG_FAULT_ALERT_MASK: rd_d = amask_q;
      `REG_METER_CONTROL:    rd_d = meter_q;
      `REG_REBOOT_CONTROL:   rd_d = {6'h00, cooling, 1'b0};
      `REG_NVM_DEFAULT:      rd_d = nvm_q;
      default:
      begin
        if (reg_addr >= `REG_ALARM_LOG_FIRST &&
            reg_addr <= `REG_ALARM_LOG_LAST)
          rd_d = alarm_q[reg_addr[2:0] - 3'd5];
      end
    endcase
  end

  // Read data is registered, one cycle after the strobe.
  always @(posedge clk)
  begin
    if (srst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_d;
  end

endmodule // fault_onoff_supervisor

// ===== fault_onoff_supervisor_assertions.sv
// Concurrent checks on the ports of the fault and on/off supervisor.
`timescale 1ns/100ps
module fault_onoff_supervisor_checker #(
  parameter TICK_CYCLES = 10000
) (
  // Clock and reset.
  input wire       clk,
  input wire       rst,
  input wire       supply_lockout,
  // Register port.
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // Pins, causes and outputs.
  input wire       presence_n,
  input wire       ov_live,
  input wire       switch_enable,
  input wire       alert_n_oe,
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  // One tick of slack, because the tick phase may shorten the count.
  localparam int DEB_MIN = 127 * TICK_CYCLES;
  logic [31:0] low_cnt_q;
  logic [31:0] low_cnt_d;

  // Saturating length of the current low run of the presence pin.
  assign low_cnt_d = (&low_cnt_q) ? low_cnt_q : low_cnt_q + 32'h1;
  always @(posedge clk)
  begin
    if (rst || presence_n)
      low_cnt_q <= 32'h0;
    else
      low_cnt_q <= low_cnt_d;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_LOCKOUT_GATE: assert property (
    supply_lockout |-> !switch_enable)
    else $error("Switch driven during lockout.");
  AST_PRESENCE_OFF: assert property (
    presence_n [*5] |-> !switch_enable)
    else $error("Switch on while presence pin is high.");
  AST_DEBOUNCE_RUN: assert property (
    $rose(switch_enable) |-> low_cnt_q >= DEB_MIN)
    else $error("Switch on before presence debounce completed.");
  AST_ON_BIT_OFF: assert property (
    reg_wr && reg_addr == 8'h0A && !reg_wdata[3] |-> ##2 !switch_enable)
    else $error("Switch still on after on bit cleared.");
  AST_ALERT_MASKED: assert property (
    reg_wr && reg_addr == 8'h15 && reg_wdata == 8'h00 |-> ##2 !alert_n_oe)
    else $error("Alert driven with every alert enable clear.");
  AST_GROUP_B_OUT: assert property (
    reg_wr && reg_addr == 8'h12 |-> ##2
      pin_out[7:4] == $past(reg_wdata[3:0], 2) &&
      pin_oe[7:4] == $past(reg_wdata[7:4], 2))
    else $error("Second pin group does not follow its register.");
  AST_PRESENCE_MIRROR: assert property (
    $stable(presence_n) [*4] ##0 (reg_rd && reg_addr == 8'h00) |=>
      reg_rdata[0] == $past(presence_n))
    else $error("System status does not mirror the presence pin.");
  AST_OV_HOLDS_OFF: assert property (
    ov_live [*3] |-> !switch_enable)
    else $error("Switch on during a live overvoltage.");

  // Main scenarios reached.
  COV_SWITCH_ON: cover property ($rose(switch_enable));
  COV_ALERT: cover property ($rose(alert_n_oe));
  COV_PIN_DRIVE: cover property ($rose(pin_oe[4]));
endmodule // fault_onoff_supervisor_checker

bind fault_onoff_supervisor fault_onoff_supervisor_checker #(
  .TICK_CYCLES(TICK_CYCLES)
) u_chk (
  .clk(clk), .rst(rst), .supply_lockout(supply_lockout),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .presence_n(presence_n), .ov_live(ov_live),
  .switch_enable(switch_enable), .alert_n_oe(alert_n_oe),
  .pin_out(pin_out), .pin_oe(pin_oe)
);

// ===== fault_onoff_host.sv
// Host model issuing single-cycle register reads and writes.
`timescale 1ns/100ps
module fault_onoff_host (
  // Clock.
  input  wire       clk,
  // Register port towards the supervisor.
  output reg        reg_wr,
  output reg        reg_rd,
  output reg  [7:0] reg_addr,
  output reg  [7:0] reg_wdata,
  input  wire [7:0] reg_rdata
);
  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // Idle port; the falling edge is used so no rising edge races us.
  initial
  begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // Strobe is held over exactly one rising edge; data is then spoiled.
  task wr(input [7:0] a, input [7:0] v);
  begin
    @(negedge clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = v;
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_wdata = ~v;
  end
  endtask

  // Read data is registered at the taking edge and ready by the next fall.
  task rd(input [7:0] a, output [7:0] v);
  begin
    @(negedge clk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    v        = reg_rdata;
  end
  endtask
endmodule // fault_onoff_host

// ===== fault_onoff_supervisor_tb.sv
// Self-checking bench for the fault and on/off supervisor.
`timescale 1ns/100ps
module fault_onoff_supervisor_tb;
  // ****************************************************************
  // Stimulus, instances and helpers
  // ****************************************************************
  reg         clk, rst, supply_lockout, presence_n, output_low_cmp;
  reg         uv_low_reset, sense_valid, pg_latched, ov_live, uv_live;
  reg         oc_live, bad_live, pg_input_live, oc_event, bad_event;
  reg         reboot_cmd, nvm_written, tick_wrap, meter_wrap;
  reg  [7:0]  pin_cmp, d;
  reg  [15:0] sense_uv;
  reg  [39:0] alarm_event;
  wire        reg_wr, reg_rd, switch_enable, alert_n_out, alert_n_oe;
  wire [7:0]  reg_addr, reg_wdata, reg_rdata, pin_out, pin_oe;
  integer     err_total, n_tests, cyc;

  // Four clocks a tick: debounce 512 clocks, shortest cooldown 2048.
  fault_onoff_supervisor #(.TICK_CYCLES(4)) dut (
    .clk(clk), .rst(rst), .supply_lockout(supply_lockout),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .presence_n(presence_n), .pin_cmp(pin_cmp),
    .output_low_cmp(output_low_cmp), .uv_low_reset(uv_low_reset),
    .sense_valid(sense_valid), .sense_uv(sense_uv),
    .pg_latched(pg_latched), .ov_live(ov_live), .uv_live(uv_live),
    .oc_live(oc_live), .bad_live(bad_live), .pg_input_live(pg_input_live),
    .oc_event(oc_event), .bad_event(bad_event), .reboot_cmd(reboot_cmd),
    .alarm_event(alarm_event), .nvm_written(nvm_written),
    .tick_wrap(tick_wrap), .meter_wrap(meter_wrap),
    .switch_enable(switch_enable), .alert_n_out(alert_n_out),
    .alert_n_oe(alert_n_oe), .pin_out(pin_out), .pin_oe(pin_oe));
  fault_onoff_host host (
    .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // Compare and count; case inequality so unknowns never match.
  task chk(input [7:0] s, input [7:0] e);
  begin
    n_tests = n_tests + 1;
    if (s !== e)
    begin
      err_total = err_total + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  end
  endtask

  // Read a register and compare the masked bits.
  task rchk(input [7:0] a, input [7:0] m, input [7:0] e);
  begin
    host.rd(a, d);
    chk(d & m, e);
  end
  endtask

  // Bounded wait for the switch to reach a level, then judge it.
  task wait_sw(input v, input integer lim);
    integer i;
  begin
    i = 0;
    while (switch_enable !== v && i < lim)
    begin
      @(negedge clk);
      i = i + 1;
    end
    chk({7'h00, switch_enable}, {7'h00, v});
  end
  endtask

  task settle(input integer n);
  begin
    repeat (n) @(negedge clk);
  end
  endtask

  task sense(input [15:0] v);
  begin
    sense_uv = v;
    sense_valid = 1'b1;
    settle(1);
    sense_valid = 1'b0;
    settle(4);
  end
  endtask

  task complete_run;
  begin
    $display("Comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Quiet start, then debounced presence and the on bit.
  task t_start;
  begin
    chk({7'h00, switch_enable}, 8'h00);
    rchk(8'h04, 8'hFF, 8'h00);
    rchk(8'h01, 8'hFF, 8'h00);
    rchk(8'h02, 8'hFF, 8'h08);
    presence_n = 1'b0;
    settle(600);
    rchk(8'h00, 8'h03, 8'h00);
    rchk(8'h05, 8'h80, 8'h80);
    host.wr(8'h0A, 8'h08);
    wait_sw(1'b1, 3);
    host.wr(8'h0B, 8'h25);
  end
  endtask

  // Active-low outside fault with gate kill, alert and a restarted cooldown.
  task t_outside;
  begin
    host.wr(8'h10, 8'h80);
    host.wr(8'h0F, 8'h80);
    host.wr(8'h15, 8'h20);
    pin_cmp[3] = 1'b0;
    settle(6);
    chk({7'h00, switch_enable}, 8'h00);
    chk({7'h00, alert_n_oe}, 8'h01);
    chk({7'h00, alert_n_out}, 8'h00);
    rchk(8'h03, 8'h20, 8'h20);
    host.wr(8'h04, 8'h00);
    rchk(8'h04, 8'h20, 8'h20);
    pin_cmp[3] = 1'b1;
    settle(6);
    rchk(8'h03, 8'h20, 8'h00);
    rchk(8'hA2, 8'h02, 8'h02);
    settle(990);
    oc_event = 1'b1;
    settle(1);
    oc_event = 1'b0;
    settle(1900);
    chk({7'h00, switch_enable}, 8'h00);
    wait_sw(1'b1, 300);
    rchk(8'hA2, 8'h02, 8'h00);
    rchk(8'h04, 8'h20, 8'h20);
    chk({7'h00, alert_n_oe}, 8'h01);
    host.wr(8'h15, 8'h00);
    settle(2);
    chk({7'h00, alert_n_oe}, 8'h00);
    host.wr(8'h04, 8'h00);
    rchk(8'h04, 8'hFF, 8'h00);
  end
  endtask

  // Retrying overvoltage, then software-set latch-off and reboot.
  task t_retry;
  begin
    ov_live = 1'b1;
    settle(4);
    chk({7'h00, switch_enable}, 8'h00);
    ov_live = 1'b0;
    wait_sw(1'b1, 4);
    rchk(8'h04, 8'h01, 8'h01);
    host.wr(8'h04, 8'h00);
    host.wr(8'h0B, 8'h00);
    host.wr(8'h04, 8'h20);
    wait_sw(1'b0, 4);
    settle(100);
    chk({7'h00, switch_enable}, 8'h00);
    host.wr(8'h04, 8'h00);
    rchk(8'hA2, 8'h02, 8'h02);
    chk({7'h00, switch_enable}, 8'h00);
    reboot_cmd = 1'b1;
    settle(1);
    reboot_cmd = 1'b0;
    wait_sw(1'b1, 8);
    rchk(8'hA2, 8'h02, 8'h00);
    host.wr(8'h0B, 8'h25);
    host.wr(8'h04, 8'h20);
    settle(4);
    chk({7'h00, switch_enable}, 8'h01);
  end
  endtask

  // On bit falling, short boundary, output collapse and low UV reset.
  task t_faults;
  begin
    host.wr(8'h0A, 8'h00);
    wait_sw(1'b0, 4);
    rchk(8'h04, 8'hFF, 8'h00);
    rchk(8'h05, 8'h80, 8'h00);
    sense(16'd255);
    rchk(8'h03, 8'h10, 8'h00);
    sense(16'd256);
    rchk(8'h03, 8'h10, 8'h10);
    rchk(8'h04, 8'h10, 8'h10);
    pg_latched = 1'b1;
    output_low_cmp = 1'b1;
    settle(6);
    rchk(8'h04, 8'h40, 8'h40);
    output_low_cmp = 1'b0;
    settle(6);
    rchk(8'h03, 8'h40, 8'h00);
    uv_low_reset = 1'b1;
    settle(6);
    uv_low_reset = 1'b0;
    settle(4);
    rchk(8'h04, 8'h40, 8'h00);
  end
  endtask

  // General-purpose pins, alarm logs and supply lockout.
  task t_pins_alarms;
  begin
    host.wr(8'h10, 8'h55);
    host.wr(8'h11, 8'hA0);
    host.wr(8'h12, 8'hF5);
    settle(3);
    chk(pin_out, 8'h5A);
    chk(pin_oe, 8'hFF);
    pin_cmp = 8'h3C;
    settle(6);
    rchk(8'h02, 8'hFF, 8'h3C);
    alarm_event[8] = 1'b1;
    nvm_written = 1'b1;
    tick_wrap = 1'b1;
    meter_wrap = 1'b1;
    settle(1);
    {alarm_event[8], nvm_written, tick_wrap, meter_wrap} = 4'h0;
    rchk(8'h06, 8'h01, 8'h01);
    rchk(8'h05, 8'h40, 8'h40);
    rchk(8'h84, 8'hC0, 8'hC0);
    host.wr(8'h06, 8'h00);
    rchk(8'h06, 8'hFF, 8'h00);
    supply_lockout = 1'b1;
    settle(2);
    supply_lockout = 1'b0;
    settle(4);
    rchk(8'h05, 8'h40, 8'h00);
    rchk(8'h84, 8'hC0, 8'h00);
  end
  endtask

  // Active-high outside fault without gate kill, then presence removed.
  task t_polarity;
  begin
    host.wr(8'h0A, 8'h08);
    wait_sw(1'b1, 700);
    host.wr(8'h10, 8'hC0);
    settle(6);
    rchk(8'h03, 8'h20, 8'h20);
    chk({7'h00, switch_enable}, 8'h01);
    presence_n = 1'b1;
    settle(8);
    chk({7'h00, switch_enable}, 8'h00);
    rchk(8'h00, 8'h01, 8'h01);
    host.wr(8'h0A, 8'h28);
    oc_live = 1'b1;
    settle(2);
    chk(pin_oe & 8'h02, 8'h02);
    chk(pin_out & 8'h02, 8'h00);
    oc_live = 1'b0;
    settle(2);
    chk(pin_oe & 8'h02, 8'h00);
  end
  endtask

  // ****************************************************************
  // Clock, timeout and main sequence
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Whole run needs under 8000 clocks; a hang is cut at 20000.
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      err_total = err_total + 1;
      complete_run;
    end
  end

  initial
  begin
    {rst, presence_n} = 2'b11;
    {supply_lockout, output_low_cmp, uv_low_reset, sense_valid} = 4'h0;
    {pg_latched, ov_live, uv_live, oc_live, bad_live} = 5'h00;
    {pg_input_live, oc_event, bad_event, reboot_cmd} = 4'h0;
    {nvm_written, tick_wrap, meter_wrap} = 3'h0;
    pin_cmp = 8'h08;
    sense_uv = 16'h0000;
    alarm_event = 40'h0;
    {err_total, n_tests, cyc} = 96'h0;
    settle(16);
    rst = 1'b0;
    settle(4);
    t_start;
    t_outside;
    t_retry;
    t_faults;
    t_pins_alarms;
    t_polarity;
    complete_run;
  end
endmodule // fault_onoff_supervisor_tb
